/* swc_regs.vh */
// register map and timing constants for the sleep/wake controller
`ifndef SWC_REGS_VH
`define SWC_REGS_VH
`define SWC_CTRL_OFS      12'h000
`define SWC_STAT_OFS      12'h004
`define SWC_SRC_EN_OFS    12'h008
`define SWC_CTRL_XTAL_BIT 0
`define SWC_CTRL_WDT_BIT  1
`define SWC_CTRL_GIE_BIT  2
`define SWC_STAT_TO_BIT   0
`define SWC_STAT_PD_BIT   1
`define SWC_STAT_SLP_BIT  2
`define SWC_STAT_WKRST_BIT 3
`define SWC_STAT_WKWDT_BIT 4
`define SWC_STAT_WKIRQ_BIT 5
`define SWC_SRC_EN_RST    6'h00
`define SWC_OST_PERIODS   1024
`define SWC_DUMMY_CYCLES  2
`define SWC_IRQ_VECTOR    16'h0004
`endif

/* swc_sleep_wake.v */
// sleep/wake controller: sleep entry, flags, wake sources, start-up delay, vectoring
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`include "swc_regs.vh"
module swc_sleep_wake #(
  parameter OST_CYCLES = `SWC_OST_PERIODS
) (
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // core sequencer
  input  wire        sleep_exec,
  input  wire        watchdog_clear_instr,
  input  wire        watchdog_timeout,
  output reg         prefetch_next,
  output reg         dummy_cycle,
  output reg         vector_fetch,
  output reg  [15:0] vector_addr,
  output reg         core_run,
  // interrupt flags, bit order: tmr1 async, capture, adc rc, comp, ioc, ext pin
  input  wire [5:0]  wake_irq_flag,
  input  wire        periph_sync_irq,
  // reset pin, active low, from a pin
  input  wire        master_reset_pin_n,
  // power and pins
  output reg         osc_drive_en,
  output reg         clk_gate_en,
  output reg         io_hold,
  output reg         wdt_clear,
  output reg         dev_reset,
  output reg         periph_irq_block,
  output reg         power_down_flag,
  output reg         time_out_flag
);
  localparam ST_RUN  = 5'b00001;
  localparam ST_SLP  = 5'b00010;
  localparam ST_OST  = 5'b00100;
  localparam ST_PRE  = 5'b01000;
  localparam ST_DUM  = 5'b10000;

  reg [4:0]  state_reg;
  reg [10:0] ost_cnt_reg;
  reg [1:0]  dum_cnt_reg;
  reg        rst_s1_reg;
  reg        rst_s2_reg;
  reg        xtal_mode_reg;
  reg        wdt_en_reg;
  reg        gie_reg;
  reg [5:0]  src_en_reg;
  reg        wk_rst_reg;
  reg        wk_wdt_reg;
  reg        wk_irq_reg;
  reg        vec_pend_reg;

  // enabled pending source; gie plays no part in waking
  wire irq_wake = |(wake_irq_flag & src_en_reg);
  wire apb_wr   = psel & penable & pwrite;
  wire apb_rd   = psel & penable & ~pwrite;

  function addr_ok;
    input [11:0] a;
    begin
      addr_ok = (a == `SWC_CTRL_OFS) || (a == `SWC_STAT_OFS) || (a == `SWC_SRC_EN_OFS);
    end
  endfunction

  // reset pin passes two flops before any logic sees it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= 1'b1;
    end else begin
      rst_s1_reg <= master_reset_pin_n;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  // apb registers, single wait-free access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_mode_reg <= 1'b0;
      wdt_en_reg    <= 1'b1;
      gie_reg       <= 1'b0;
      src_en_reg    <= `SWC_SRC_EN_RST;
      prdata        <= 32'h00000000;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok(paddr);
      if (apb_wr && pready && paddr == `SWC_CTRL_OFS) begin
        xtal_mode_reg <= pwdata[`SWC_CTRL_XTAL_BIT];
        wdt_en_reg    <= pwdata[`SWC_CTRL_WDT_BIT];
        gie_reg       <= pwdata[`SWC_CTRL_GIE_BIT];
      end
      if (apb_wr && pready && paddr == `SWC_SRC_EN_OFS)
        src_en_reg <= pwdata[5:0];
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `SWC_CTRL_OFS:
            prdata <= {29'h0, gie_reg, wdt_en_reg, xtal_mode_reg};
          `SWC_STAT_OFS:
            prdata <= {26'h0, wk_irq_reg, wk_wdt_reg, wk_rst_reg,
                       (state_reg != ST_RUN), power_down_flag, time_out_flag};
          `SWC_SRC_EN_OFS:
            prdata <= {26'h0, src_en_reg};
          default:
            prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // sleep/wake sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg        <= ST_RUN;
      ost_cnt_reg      <= 11'h000;
      dum_cnt_reg      <= 2'h0;
      power_down_flag  <= 1'b1;
      time_out_flag    <= 1'b1;
      wk_rst_reg       <= 1'b0;
      wk_wdt_reg       <= 1'b0;
      wk_irq_reg       <= 1'b0;
      vec_pend_reg     <= 1'b0;
      osc_drive_en     <= 1'b1;
      clk_gate_en      <= 1'b1;
      io_hold          <= 1'b0;
      wdt_clear        <= 1'b0;
      dev_reset        <= 1'b1;
      periph_irq_block <= 1'b0;
      prefetch_next    <= 1'b0;
      dummy_cycle      <= 1'b0;
      vector_fetch     <= 1'b0;
      vector_addr      <= 16'h0000;
      core_run         <= 1'b0;
    end else begin
      wdt_clear     <= 1'b0;
      prefetch_next <= 1'b0;
      dummy_cycle   <= 1'b0;
      vector_fetch  <= 1'b0;
      dev_reset     <= 1'b0;
      core_run      <= 1'b1;
      if (!rst_s2_reg) begin
        // pin reset returns any state to run with dev_reset, apb registers keep their values; watchdog never touches the pin
        state_reg        <= ST_RUN;
        power_down_flag  <= 1'b1;
        time_out_flag    <= 1'b1;
        wk_rst_reg       <= (state_reg == ST_SLP);
        dev_reset        <= 1'b1;
        core_run         <= 1'b0;
        osc_drive_en     <= 1'b1;
        clk_gate_en      <= 1'b1;
        io_hold          <= 1'b0;
        periph_irq_block <= 1'b0;
        vec_pend_reg     <= 1'b0;
      end else begin
        case (state_reg)
          ST_RUN: begin
            if (watchdog_clear_instr)
              wdt_clear <= 1'b1;
            if (watchdog_timeout && wdt_en_reg) begin
              dev_reset     <= 1'b1;
              time_out_flag <= 1'b0;
              core_run      <= 1'b0;
            end else if (sleep_exec && !irq_wake) begin
              // pending enabled source makes sleep a nop instead
              state_reg        <= ST_SLP;
              wdt_clear        <= 1'b1;
              power_down_flag  <= 1'b0;
              time_out_flag    <= 1'b1;
              osc_drive_en     <= 1'b0;
              clk_gate_en      <= 1'b0;
              io_hold          <= 1'b1;
              periph_irq_block <= 1'b1;
              prefetch_next    <= 1'b1;
              core_run         <= 1'b0;
              wk_rst_reg       <= 1'b0;
              wk_wdt_reg       <= 1'b0;
              wk_irq_reg       <= 1'b0;
            end
          end
          ST_SLP: begin
            core_run <= 1'b0;
            // irq arriving during sleep still wakes next cycle
            if ((watchdog_timeout && wdt_en_reg) || irq_wake) begin
              wdt_clear     <= 1'b1;
              wk_wdt_reg    <= watchdog_timeout & wdt_en_reg;
              wk_irq_reg    <= ~(watchdog_timeout & wdt_en_reg);
              if (watchdog_timeout && wdt_en_reg)
                time_out_flag <= 1'b0;
              vec_pend_reg  <= irq_wake & gie_reg & ~(watchdog_timeout & wdt_en_reg);
              osc_drive_en  <= 1'b1;
              ost_cnt_reg   <= 11'h000;
              state_reg     <= xtal_mode_reg ? ST_OST : ST_PRE;
            end
          end
          ST_OST: begin
            // clock runs for the count but is still gated from the core
            core_run    <= 1'b0;
            wdt_clear   <= 1'b1;
            ost_cnt_reg <= ost_cnt_reg + 11'h001;
            if (ost_cnt_reg == OST_CYCLES[10:0] - 11'h001)
              state_reg <= ST_PRE;
          end
          ST_PRE: begin
            // prefetched instruction executes first
            clk_gate_en      <= 1'b1;
            io_hold          <= 1'b0;
            periph_irq_block <= 1'b0;
            dum_cnt_reg      <= 2'h0;
            state_reg        <= vec_pend_reg ? ST_DUM : ST_RUN;
          end
          ST_DUM: begin
            dummy_cycle <= 1'b1;
            dum_cnt_reg <= dum_cnt_reg + 2'h1;
            if (dum_cnt_reg == `SWC_DUMMY_CYCLES - 1) begin
              vector_fetch <= 1'b1;
              vector_addr  <= `SWC_IRQ_VECTOR;
              vec_pend_reg <= 1'b0;
              state_reg    <= ST_RUN;
            end
          end
          default: state_reg <= ST_RUN;
        endcase
      end
    end
  end

  // sync interrupts are simply ignored in every state; they never reach the flags
  wire unused_sync = periph_sync_irq;
endmodule // swc_sleep_wake

/* swc_sleep_wake_monitor.sv */
// assertions and covers on the sleep/wake controller ports
`include "swc_regs.vh"
module swc_sleep_wake_monitor (
  // watched ports
  input logic pclk, presetn, watchdog_timeout, master_reset_pin_n, prefetch_next,
  input logic dummy_cycle, vector_fetch, core_run, osc_drive_en, clk_gate_en, io_hold,
  input logic wdt_clear, dev_reset, periph_irq_block, power_down_flag, time_out_flag,
  input logic [15:0] vector_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ENTRY: assert property ($rose(io_hold) |-> !power_down_flag && time_out_flag)
    else $error("entry flags wrong");
  AST_PREFETCH: assert property ($rose(io_hold) |-> prefetch_next && wdt_clear)
    else $error("entry without prefetch");
  AST_OSC_OFF: assert property ($rose(io_hold) |-> !osc_drive_en && !clk_gate_en)
    else $error("clocks run in sleep");
  AST_HALT: assert property (io_hold |-> !core_run && periph_irq_block)
    else $error("activity in sleep");
  AST_PIN_RST: assert property ($fell(master_reset_pin_n) |-> ##[1:4] dev_reset)
    else $error("reset pin ignored");
  AST_WDT_CLR: assert property (io_hold && watchdog_timeout |-> ##[1:3] wdt_clear)
    else $error("no clear on wake");
  AST_TO_CLR: assert property (io_hold && watchdog_timeout |-> ##[1:3] !time_out_flag)
    else $error("time-out flag kept");
  AST_VECTOR: assert property (vector_fetch |->
    vector_addr == `SWC_IRQ_VECTOR && dummy_cycle && $past(dummy_cycle) &&
    !$past(dummy_cycle, 2))
    else $error("bad vector fetch");
  // main scenarios reached
  cover property ($rose(io_hold));
  cover property (vector_fetch);
  cover property ($rose(dev_reset));
endmodule // swc_sleep_wake_monitor
bind swc_sleep_wake swc_sleep_wake_monitor swc_sleep_wake_monitor_i (.*);

/* swc_core_model.sv */
// far-side model: core, wake sources, reset pin
module swc_core_model (
  // toward the controller
  input logic pclk,
  output logic sleep_exec, watchdog_clear_instr, watchdog_timeout, periph_sync_irq,
  output logic master_reset_pin_n,
  output logic [5:0] wake_irq_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  // pin rests high so sleep is never cut short
  initial {sleep_exec, watchdog_clear_instr, watchdog_timeout, periph_sync_irq,
    master_reset_pin_n, wake_irq_flag} = 11'h040;
  // one-cycle sleep or time-out pulse
  task automatic op(input logic s, input logic w);
    sleep_exec <= s;
    watchdog_timeout <= w;
    @(posedge pclk);
    sleep_exec <= 1'h0;
    watchdog_timeout <= 1'h0;
  endtask
  // level flags, held until software would clear them
  task automatic src(input logic [5:0] f, input logic p);
    wake_irq_flag <= f;
    periph_sync_irq <= p;
  endtask
  task automatic pin(input int n);
    master_reset_pin_n <= 1'h0;
    repeat (n) @(posedge pclk);
    master_reset_pin_n <= 1'h1;
  endtask
endmodule // swc_core_model

/* tb_swc_sleep_wake.sv */
// self-checking bench for the sleep/wake controller
`include "swc_regs.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_swc_sleep_wake;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OST = 8;
  typedef struct {int src; logic global_irq_enable, xtal, to, vec;} swc_row_t;
  swc_row_t rows[7] = '{'{0,1,0,1,1}, '{1,0,1,1,0}, '{2,1,1,1,1}, '{3,0,0,1,0},
    '{4,1,0,1,1}, '{5,0,1,1,0}, '{6,1,1,0,0}};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_exec, watchdog_timeout;
  logic watchdog_clear_instr, periph_sync_irq, master_reset_pin_n, prefetch_next, dummy_cycle;
  logic vector_fetch, core_run, osc_drive_en, clk_gate_en, io_hold, wdt_clear, dev_reset;
  logic periph_irq_block, power_down_flag, time_out_flag, err, seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] vector_addr;
  logic [5:0]  wake_irq_flag;
  int          error_cnt = 0, total_checks = 0, c;
  swc_sleep_wake #(.OST_CYCLES(OST)) swc_sleep_wake_i (.*);
  swc_core_model core_m (.*);
  initial begin pclk = 1'h0; forever #20 pclk = ~pclk; end
  // latch a vector fetch between checks
  always @(posedge pclk) if (vector_fetch === 1'h1) seen <= 1'h1;
  // idle cycle at the end keeps back-to-back calls apart
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    do begin @(posedge pclk); n++; end while (pready !== 1'h1 && n < 50);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask
  task automatic wait_run();
    c = 0;
    do begin @(posedge pclk); c++; end while (core_run !== 1'h1 && c < 500);
  endtask
  task automatic sleep_chk();
    core_m.op(1'h1, 1'h0);
    repeat (2) @(posedge pclk);
    `CHK("pd", 1'h0, power_down_flag)
    `CHK("to", 1'h1, time_out_flag)
    `CHK("hold", 1'h1, io_hold)
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // hang guard, far beyond the expected run
  initial begin #400000; error_cnt++; finish_test(); end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    `CHK("pd_por", 1'h1, power_down_flag)
    apb(1'h0, `SWC_STAT_OFS, 32'h0);
    `CHK("stat_por", 32'h00000003, rd)
    apb(1'h0, 12'hFFC, 32'h0);
    `CHK("slverr", 1'h1, err)
    foreach (rows[i]) begin
      apb(1'h1, `SWC_CTRL_OFS, {29'h0, rows[i].global_irq_enable, 1'h1, rows[i].xtal});
      apb(1'h1, `SWC_SRC_EN_OFS, 32'h3F);
      sleep_chk();
      seen = 1'h0;
      if (rows[i].src == 6) core_m.op(1'h0, 1'h1);
      else core_m.src(6'h01 << rows[i].src, 1'h0);
      wait_run();
      `CHK("ost", rows[i].xtal, c >= OST)
      repeat (6) @(posedge pclk);
      `CHK("vec", rows[i].vec, seen)
      `CHK("to_w", rows[i].to, time_out_flag)
      core_m.src(6'h00, 1'h0);
      $display("row %0d done", i);
    end
    // disabled source and clocked peripherals must not wake
    apb(1'h1, `SWC_SRC_EN_OFS, 32'h3E);
    sleep_chk();
    core_m.src(6'h01, 1'h1);
    repeat (10) @(posedge pclk);
    `CHK("asleep", 1'h1, io_hold)
    core_m.pin(4);
    wait_run();
    `CHK("pd_pin", 1'h1, power_down_flag)
    // pending enabled flag turns sleep into a no-op
    apb(1'h1, `SWC_SRC_EN_OFS, 32'h3F);
    core_m.src(6'h02, 1'h0);
    @(posedge pclk);
    core_m.op(1'h1, 1'h0);
    repeat (3) @(posedge pclk);
    `CHK("nop_pd", 1'h1, power_down_flag)
    `CHK("nop_hold", 1'h0, io_hold)
    $display("edge cases done");
    finish_test();
  end
endmodule // tb_swc_sleep_wake
